/* File: lpw_ctrl.sv */
// power-mode and wake-up controller: sleep, deep-sleep and deep power-down sequencing with an AHB-Lite slave
// assumes wake sources arrive asynchronously; bus signals are on CLK; RESETN is the external reset pin
`timescale 1ns/1ps
`include "lpw_cfg.svh"
module lpw_ctrl (
    input  wire logic                  CLK,
    input  wire logic                  RESETN,
    input  wire logic                  HSEL,
    input  wire logic [31:0]           HADDR,
    input  wire logic [1:0]            HTRANS,
    input  wire logic                  HWRITE,
    input  wire logic [2:0]            HSIZE,
    input  wire logic [31:0]           HWDATA,
    input  wire logic                  HREADY,
    output logic      [31:0]           HRDATA,
    output logic                       HREADYOUT,
    output logic                       HRESP,
    input  wire lpw_pkg::lpw_wake_src_t WAKE_SRC,
    output lpw_pkg::lpw_pwr_ctl_t      POWER_CTL,
    output logic                       RTC_WAKE_IRQ,
    output logic                       WAKE_PULSE,
    output logic                       CHIP_RESET_REQ
);
    import lpw_pkg::*;

    lpw_wake_src_t src_meta_q;
    lpw_wake_src_t src_q;
    lpw_state_t    state_q;
    lpw_state_t    state_d;
    lpw_pwr_ctl_t  pwr_d;
    logic [7:0]    addr_q;
    logic          wr_pend_q;
    logic          rd_pend_q;
    logic          acc;
    logic          we;
    logic [1:0]    mode_req;
    logic          mode_we;
    logic [15:0]   start0_q;
    logic [3:0]    start1_q;
    logic [2:0]    bod_q;
    logic [2:0]    pdrun_q;
    logic [3:0]    clk_q;
    logic [1:0]    wdt_q;
    logic [3:0]    cause_q;
    logic [3:0]    cause_d;
    logic [3:0]    rst_cnt_q;
    logic          soft_clr;
    logic [10:0]   wake_vec;
    logic          deep_wake;
    logic          reset_wake;
    logic          dpd_wake;
    logic          sleep_wake;
    logic [31:0]   rdata;

    // field helpers, naming the bits of the configuration registers
    logic bod_int_en, bod_rst_en, bod_keep;
    logic wdt_osc_on, wdt_keep, dma_keep;
    logic osc_1hz, osc_1khz, rtc_bus_clk, micro_tick_timer_clk;
    logic wdt_int_en, wdt_rst_en;
    assign bod_int_en  = bod_q[0];
    assign bod_rst_en  = bod_q[1];
    assign bod_keep    = bod_q[2];
    assign wdt_osc_on  = pdrun_q[0];
    assign wdt_keep    = pdrun_q[1];
    assign dma_keep    = pdrun_q[2];
    assign osc_1hz     = clk_q[0];
    assign osc_1khz    = clk_q[1];
    assign rtc_bus_clk = clk_q[2];
    assign micro_tick_timer_clk   = clk_q[3];
    assign wdt_int_en  = wdt_q[0];
    assign wdt_rst_en  = wdt_q[1];

    function automatic logic word_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // wake sources come from other clock and power domains
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            src_meta_q <= '0;
            src_q      <= '0;
        end else begin
            src_meta_q <= WAKE_SRC;
            src_q      <= src_meta_q;
        end
    end

    // bus slave: writes take no wait state, reads one so that read data leaves a flip-flop
    assign acc = HSEL && HREADY && HTRANS[1];
    assign we  = wr_pend_q && HREADY;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            addr_q    <= 8'h00;
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            HREADYOUT <= 1'b1;
            HRDATA    <= 32'h0000_0000;
            HRESP     <= 1'b0;
        end else if (rd_pend_q) begin
            rd_pend_q <= 1'b0;
            HRDATA    <= rdata;
            HREADYOUT <= 1'b1;
        end else if (HREADY) begin
            wr_pend_q <= acc && HWRITE;
            rd_pend_q <= acc && !HWRITE;
            HREADYOUT <= !(acc && !HWRITE);
            if (acc) begin
                addr_q <= HADDR[7:0];
            end
        end
    end

    assign mode_we  = we && word_hit(addr_q, `LPW_A_MODE);
    assign mode_req = HWDATA[1:0];

    // configuration registers return to reset values on the pin reset and after every restart through ST_RESET (deep power-down alarm, brownout or watchdog reset)
    assign soft_clr = (state_q == ST_RESET) && (rst_cnt_q == 4'h0);

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            start0_q <= `LPW_START0_RST;
            start1_q <= `LPW_START1_RST;
        end else if (soft_clr) begin
            start0_q <= `LPW_START0_RST;
            start1_q <= `LPW_START1_RST;
        end else begin
            if (we && word_hit(addr_q, `LPW_A_START0)) begin
                start0_q <= HWDATA[15:0];
            end
            if (we && word_hit(addr_q, `LPW_A_START1)) begin
                start1_q <= HWDATA[3:0];
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            bod_q   <= `LPW_BOD_RST;
            pdrun_q <= `LPW_PDRUN_RST;
            clk_q   <= `LPW_CLK_RST;
            wdt_q   <= `LPW_WDT_RST;
        end else if (soft_clr) begin
            bod_q   <= `LPW_BOD_RST;
            pdrun_q <= `LPW_PDRUN_RST;
            clk_q   <= `LPW_CLK_RST;
            wdt_q   <= `LPW_WDT_RST;
        end else begin
            if (we && word_hit(addr_q, `LPW_A_BODCFG)) begin
                bod_q <= HWDATA[2:0];
            end
            if (we && word_hit(addr_q, `LPW_A_PDRUN)) begin
                pdrun_q <= HWDATA[2:0];
            end
            if (we && word_hit(addr_q, `LPW_A_CLKCFG)) begin
                clk_q <= HWDATA[3:0];
            end
            if (we && word_hit(addr_q, `LPW_A_WDTMODE)) begin
                wdt_q <= HWDATA[1:0];
            end
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        unique case (addr_q)
            `LPW_A_STATUS:  rdata = {20'h00000, cause_q, 3'h0, state_q};
            `LPW_A_START0:  rdata = {16'h0000, start0_q};
            `LPW_A_START1:  rdata = {28'h0000000, start1_q};
            `LPW_A_BODCFG:  rdata = {29'h00000000, bod_q};
            `LPW_A_PDRUN:   rdata = {29'h00000000, pdrun_q};
            `LPW_A_CLKCFG:  rdata = {28'h0000000, clk_q};
            `LPW_A_WDTMODE: rdata = {30'h00000000, wdt_q};
            default:        rdata = 32'h0000_0000;
        endcase
    end

    // deep-sleep wake terms: every term is a request gated by its enables
    always_comb begin
        wake_vec[0] = |(src_q.pin_irq & src_q.processor_interrupt_controller_en_pin
                        & (start0_q[`LPW_SE_PIN0 +: 4] | start1_q));
        wake_vec[1] = src_q.bod_irq && src_q.processor_interrupt_controller_en_bod && start0_q[`LPW_SE_BOD]
                      && bod_int_en && bod_keep;
        wake_vec[2] = src_q.wdt_irq && wdt_osc_on && wdt_keep && src_q.wdt_running
                      && wdt_int_en && src_q.processor_interrupt_controller_en_wdt && start0_q[`LPW_SE_WDT];
        wake_vec[3] = src_q.rtc_second_alarm_flag && osc_1hz && rtc_bus_clk
                      && src_q.rtc_alarm_armed && start0_q[`LPW_SE_ALARM];
        wake_vec[4] = src_q.rtc_wake_timeout && osc_1hz && osc_1khz
                      && src_q.rtc_wake_armed && start0_q[`LPW_SE_RTCWAKE];
        wake_vec[5] = src_q.micro_tick_timer_irq && wdt_osc_on && micro_tick_timer_clk
                      && src_q.micro_tick_timer_started && start0_q[`LPW_SE_MICRO_TICK_TIMER];
        wake_vec[6] = src_q.usart_irq && (src_q.usart_sync_slave || src_q.usart_low_freq)
                      && start0_q[`LPW_SE_USART];
        wake_vec[7] = src_q.spi_irq && src_q.spi_slave && start0_q[`LPW_SE_SPI];
        wake_vec[8] = src_q.i2c_irq && src_q.i2c_slave && start0_q[`LPW_SE_I2C];
        wake_vec[9] = src_q.usb_need_clock && start0_q[`LPW_SE_USB];
        wake_vec[10] = src_q.serial_hw_wake_request && start0_q[`LPW_SE_SERIAL_HW_WAKE_REQUEST];
    end

    assign deep_wake  = |wake_vec;
    assign reset_wake = (src_q.bod_event && bod_rst_en)
                        || (src_q.wdt_reset && wdt_osc_on && wdt_rst_en && src_q.wdt_running);
    // only the alarm can wake from deep power-down; the pin reset acts through RESETN
    assign dpd_wake   = src_q.rtc_second_alarm_flag && osc_1hz && src_q.rtc_alarm_armed;
    assign sleep_wake = src_q.processor_interrupt_controller_irq_pending || src_q.serial_hw_wake_request;

    always_comb begin
        state_d = state_q;
        cause_d = cause_q;
        unique case (state_q)
            ST_ACTIVE: begin
                if (mode_we && mode_req == `LPW_MODE_SLEEP) begin
                    state_d = ST_SLEEP;
                end else if (mode_we && mode_req == `LPW_MODE_DEEP) begin
                    state_d = ST_DEEP;
                end else if (mode_we && mode_req == `LPW_MODE_DPD) begin
                    state_d = ST_DPD;
                end
            end
            ST_SLEEP: begin
                if (sleep_wake) begin
                    state_d = ST_ACTIVE;
                    cause_d = `LPW_CAUSE_IRQ;
                end
            end
            ST_DEEP: begin
                if (reset_wake) begin
                    state_d = ST_RESET;
                    cause_d = `LPW_CAUSE_RESET;
                end else if (deep_wake) begin
                    state_d = ST_ACTIVE;
                    cause_d = `LPW_CAUSE_DEEP;
                end
            end
            ST_DPD: begin
                if (dpd_wake) begin
                    state_d = ST_RESET;
                    cause_d = `LPW_CAUSE_DPD;
                end
            end
            ST_RESET: begin
                if (rst_cnt_q == 4'h0) begin
                    state_d = ST_ACTIVE;
                end
            end
            default: begin
                state_d = ST_ACTIVE;
            end
        endcase
    end

    // the pin reset always returns the part to active with nothing else to enable
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= ST_ACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    // wake cause survives the soft clear so software can see why it restarted
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cause_q <= `LPW_CAUSE_NONE;
        end else begin
            cause_q <= cause_d;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_cnt_q <= `LPW_RST_CYCLES;
        end else if (state_q == ST_RESET) begin
            rst_cnt_q <= rst_cnt_q - 4'h1;
        end else begin
            rst_cnt_q <= `LPW_RST_CYCLES;
        end
    end

    // clock and power enables per mode
    always_comb begin
        pwr_d = '0;
        unique case (state_q)
            ST_ACTIVE: begin
                pwr_d.cpu_clk_en      = 1'b1;
                pwr_d.main_clk_en     = 1'b1;
                pwr_d.periph_clk_en   = 1'b1;
                pwr_d.serial_clk_en   = 1'b1;
                pwr_d.fro_en          = 1'b1;
                pwr_d.pll_en          = 1'b1;
                pwr_d.flash_pwr       = 1'b1;
                pwr_d.dma_clk_en      = 1'b1;
                pwr_d.bod_run         = 1'b1;
                pwr_d.wdt_osc_run     = wdt_osc_on;
                pwr_d.core_domain_pwr = 1'b1;
            end
            ST_SLEEP: begin
                pwr_d.cpu_clk_en      = 1'b0;
                pwr_d.main_clk_en     = 1'b1;
                pwr_d.periph_clk_en   = 1'b1;
                pwr_d.serial_clk_en   = 1'b1;
                pwr_d.fro_en          = 1'b1;
                pwr_d.pll_en          = 1'b1;
                pwr_d.flash_pwr       = 1'b1;
                pwr_d.dma_clk_en      = 1'b1;
                pwr_d.bod_run         = 1'b1;
                pwr_d.wdt_osc_run     = wdt_osc_on;
                pwr_d.core_domain_pwr = 1'b1;
            end
            ST_DEEP: begin
                pwr_d.flash_pwr       = 1'b1;
                pwr_d.flash_standby   = 1'b1;
                pwr_d.serial_clk_en   = 1'b0;
                pwr_d.dma_clk_en      = dma_keep;
                pwr_d.bod_run         = bod_keep;
                pwr_d.wdt_osc_run     = wdt_osc_on && wdt_keep;
                pwr_d.core_domain_pwr = 1'b1;
            end
            ST_DPD: begin
                pwr_d.core_domain_pwr = 1'b0;
                pwr_d.pins_hiz        = 1'b1;
            end
            ST_RESET: begin
                pwr_d.core_domain_pwr = 1'b1;
                pwr_d.pins_hiz        = 1'b1;
                pwr_d.flash_pwr       = 1'b1;
            end
            default: begin
                pwr_d = '0;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            POWER_CTL <= '0;
        end else begin
            POWER_CTL <= pwr_d;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            RTC_WAKE_IRQ   <= 1'b0;
            WAKE_PULSE     <= 1'b0;
            CHIP_RESET_REQ <= 1'b0;
        end else begin
            RTC_WAKE_IRQ   <= src_q.rtc_second_alarm_flag;
            WAKE_PULSE     <= (state_q != ST_ACTIVE) && (state_d == ST_ACTIVE);
            CHIP_RESET_REQ <= (state_d == ST_RESET);
        end
    end
endmodule

/* File: lpw_cfg.svh */
// register offsets, field positions, state codes and counts of the low-power wake-up controller
// assumes byte addresses on a 32-bit AHB-Lite bus; only haddr[7:0] is decoded
`ifndef LPW_CFG_SVH
`define LPW_CFG_SVH
`define LPW_A_MODE        8'h00
`define LPW_A_STATUS      8'h04
`define LPW_A_START0      8'h08
`define LPW_A_START1      8'h0c
`define LPW_A_BODCFG      8'h10
`define LPW_A_PDRUN       8'h14
`define LPW_A_CLKCFG      8'h18
`define LPW_A_WDTMODE     8'h1c
`define LPW_MODE_SLEEP    2'h1
`define LPW_MODE_DEEP     2'h2
`define LPW_MODE_DPD      2'h3
`define LPW_S_ACTIVE      5'h01
`define LPW_S_SLEEP       5'h02
`define LPW_S_DEEP        5'h04
`define LPW_S_DPD         5'h08
`define LPW_S_RESET       5'h10
`define LPW_SE_BOD        0
`define LPW_SE_WDT        1
`define LPW_SE_ALARM      2
`define LPW_SE_RTCWAKE    3
`define LPW_SE_MICRO_TICK_TIMER      4
`define LPW_SE_USART      5
`define LPW_SE_SPI        6
`define LPW_SE_I2C        7
`define LPW_SE_USB        8
`define LPW_SE_SERIAL_HW_WAKE_REQUEST     9
`define LPW_SE_PIN0       12
`define LPW_START0_RST    16'h0000
`define LPW_START1_RST    4'h0
`define LPW_BOD_RST       3'h0
`define LPW_PDRUN_RST     3'h0
`define LPW_CLK_RST       4'h0
`define LPW_WDT_RST       2'h0
`define LPW_RST_CYCLES    4'hf
`define LPW_CAUSE_NONE    4'h0
`define LPW_CAUSE_IRQ     4'h1
`define LPW_CAUSE_DEEP    4'h2
`define LPW_CAUSE_RESET   4'h3
`define LPW_CAUSE_DPD     4'h4
`endif

/* File: lpw_pkg.sv */
// types of the low-power wake-up controller
// assumes lpw_cfg.svh supplies the state codes
`include "lpw_cfg.svh"
package lpw_pkg;
    typedef enum logic [4:0] {
        ST_ACTIVE = `LPW_S_ACTIVE,
        ST_SLEEP  = `LPW_S_SLEEP,
        ST_DEEP   = `LPW_S_DEEP,
        ST_DPD    = `LPW_S_DPD,
        ST_RESET  = `LPW_S_RESET
    } lpw_state_t;

    typedef struct packed {
        logic [3:0] pin_irq;
        logic [3:0] processor_interrupt_controller_en_pin;
        logic       processor_interrupt_controller_en_bod;
        logic       processor_interrupt_controller_en_wdt;
        logic       processor_interrupt_controller_irq_pending;
        logic       bod_irq;
        logic       bod_event;
        logic       wdt_irq;
        logic       wdt_reset;
        logic       wdt_running;
        logic       rtc_second_alarm_flag;
        logic       rtc_alarm_armed;
        logic       rtc_wake_timeout;
        logic       rtc_wake_armed;
        logic       micro_tick_timer_irq;
        logic       micro_tick_timer_started;
        logic       usart_irq;
        logic       usart_sync_slave;
        logic       usart_low_freq;
        logic       spi_irq;
        logic       spi_slave;
        logic       i2c_irq;
        logic       i2c_slave;
        logic       usb_need_clock;
        logic       serial_hw_wake_request;
    } lpw_wake_src_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic main_clk_en;
        logic periph_clk_en;
        logic serial_clk_en;
        logic fro_en;
        logic pll_en;
        logic flash_standby;
        logic flash_pwr;
        logic dma_clk_en;
        logic bod_run;
        logic wdt_osc_run;
        logic core_domain_pwr;
        logic pins_hiz;
    } lpw_pwr_ctl_t;
endpackage

/* File: lpw_ctrl_asserts.sv */
// checker for the low-power wake-up controller ports
// assumes it is bound onto lpw_ctrl; one clock, async active-low reset
`timescale 1ns/1ps
module lpw_ctrl_asserts (
    input wire logic                   CLK,
    input wire logic                   RESETN,
    input wire logic                   HSEL,
    input wire logic [1:0]             HTRANS,
    input wire logic                   HWRITE,
    input wire logic                   HREADY,
    input wire logic                   HREADYOUT,
    input wire logic                   HRESP,
    input wire lpw_pkg::lpw_wake_src_t WAKE_SRC,
    input wire lpw_pkg::lpw_pwr_ctl_t  POWER_CTL,
    input wire logic                   RTC_WAKE_IRQ,
    input wire logic                   WAKE_PULSE,
    input wire logic                   CHIP_RESET_REQ
);
    import lpw_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    logic [2:0] up_q;
    logic [4:0] rq_q;
    // the synchroniser still holds reset values for a few edges
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) up_q <= 3'h0;
        else if (up_q != 3'h4) up_q <= up_q + 3'h1;
    end
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) rq_q <= 5'h00;
        else rq_q <= CHIP_RESET_REQ ? rq_q + 5'h01 : 5'h00;
    end
    sequence rd_req;
        HSEL && HREADY && HTRANS[1] && !HWRITE;
    endsequence
    sequence dpd_quiet;
        (POWER_CTL.pins_hiz && !WAKE_SRC.rtc_second_alarm_flag && !CHIP_RESET_REQ) [*5];
    endsequence
    a_hresp_okay: assert property (HRESP == 1'b0) else $error("error response");
    a_read_wait: assert property (rd_req |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read wait state wrong");
    a_rtc_irq_follow: assert property (up_q == 3'h4 |->
        RTC_WAKE_IRQ == $past(WAKE_SRC.rtc_second_alarm_flag, 3)) else $error("alarm irq lag");
    // the restart also floats the pins but keeps power; its last cycle lags the request by one edge
    a_dpd_power_off: assert property (POWER_CTL.pins_hiz && !CHIP_RESET_REQ && !$past(CHIP_RESET_REQ) |->
        !POWER_CTL.core_domain_pwr && !POWER_CTL.dma_clk_en && !POWER_CTL.flash_pwr)
        else $error("power left on in dpd");
    a_dpd_only_alarm: assert property (dpd_quiet |=> POWER_CTL.pins_hiz && !WAKE_PULSE)
        else $error("dpd left without alarm");
    a_deep_clocks: assert property (!POWER_CTL.main_clk_en && POWER_CTL.core_domain_pwr
        && !CHIP_RESET_REQ && !POWER_CTL.pins_hiz |-> !POWER_CTL.periph_clk_en && !POWER_CTL.fro_en
        && !POWER_CTL.cpu_clk_en && POWER_CTL.flash_standby) else $error("deep clocks on");
    a_sleep_periph: assert property (!POWER_CTL.cpu_clk_en && POWER_CTL.main_clk_en
        && !CHIP_RESET_REQ |-> POWER_CTL.periph_clk_en) else $error("sleep stopped peripherals");
    a_wake_pulse: assert property (WAKE_PULSE |=> POWER_CTL.cpu_clk_en && !WAKE_PULSE)
        else $error("wake pulse wrong");
    a_reset_len: assert property ($fell(CHIP_RESET_REQ) |-> rq_q == 5'h10)
        else $error("reset request length");
endmodule
bind lpw_ctrl lpw_ctrl_asserts u_chk (.CLK, .RESETN, .HSEL, .HTRANS, .HWRITE, .HREADY,
    .HREADYOUT, .HRESP, .WAKE_SRC, .POWER_CTL, .RTC_WAKE_IRQ, .WAKE_PULSE, .CHIP_RESET_REQ);

/* File: lpw_src_model.sv */
// wake sources: core interrupt controller and peripherals as level drivers
// assumes the bench sets the wanted levels; they change only after a clock edge
`timescale 1ns/1ps
module lpw_src_model (
    input wire logic                   clk,
    input wire lpw_pkg::lpw_wake_src_t want,
    output lpw_pkg::lpw_wake_src_t     src
);
    import lpw_pkg::*;
    // levels only, held until the bench drops them: no sticky flags out here
    always_ff @(posedge clk) begin
        src <= want;
    end
endmodule

/* File: low_power_wakeup_control_tb.sv */
// bench for lpw_ctrl: AHB-Lite master, wake source model, register model
// assumes the hand-over timing: read wait of one cycle, wake after the sync
`timescale 1ns/1ps
module low_power_wakeup_control_tb;
    import lpw_pkg::*;
    logic          clk = 0, resetn = 0, hsel = 0, hwrite = 0;
    logic [31:0]   haddr = 0, hwdata = 0, hrdata, rd, seed = 32'h3e4a5a68;
    logic [1:0]    htrans = 0;
    logic          hreadyout, hresp, rtc_irq, wake, rst_req;
    lpw_wake_src_t want = '0, src;
    lpw_pwr_ctl_t  pwr;
    int            fails = 0, n_compared = 0, i, k;
    int            regs[8];
    int            msk[8] = '{0, 0, 'hffff, 'hf, 7, 7, 'hf, 3};
    always #20 clk = ~clk;
    lpw_src_model u_src (.clk(clk), .want(want), .src(src));
    lpw_ctrl dut (.CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .WAKE_SRC(src), .POWER_CTL(pwr),
        .RTC_WAKE_IRQ(rtc_irq), .WAKE_PULSE(wake), .CHIP_RESET_REQ(rst_req));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // only the watchdog ends a stalled transfer
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        if (w && a[4:2] > 1 && a < 8'h20) regs[a[4:2]] = d & msk[a[4:2]];
    endtask
    // one deep-sleep wake source with what it needs on the source side
    function automatic lpw_wake_src_t src_for(input int j);
        lpw_wake_src_t s;
        s = '0;
        case (j)
            0: {s.pin_irq[0], s.processor_interrupt_controller_en_pin[0]} = 2'b11;
            1: {s.bod_irq, s.processor_interrupt_controller_en_bod} = 2'b11;
            2: {s.wdt_irq, s.processor_interrupt_controller_en_wdt, s.wdt_running} = 3'b111;
            3: {s.rtc_second_alarm_flag, s.rtc_alarm_armed} = 2'b11;
            4: {s.rtc_wake_timeout, s.rtc_wake_armed} = 2'b11;
            default: {s.micro_tick_timer_irq, s.micro_tick_timer_started} = 2'b11;
        endcase
        return s;
    endfunction
    task automatic rdchk(input logic [7:0] a);
        bus(0, a, 0);
        chk("register", (a < 8'h20) ? regs[a[4:2]] : 0, rd);
    endtask
    // bounded wait for the wake pulse or the reset request to reach a level
    task automatic await(input bit r, input logic v);
        int n;
        n = 0;
        do @(posedge clk); while ((r ? rst_req : wake) !== v && ++n < 60);
        chk("wake wait", 1, n < 60);
    endtask
    task automatic leave_reset;
        await(1, 1);
        await(1, 0);
        for (i = 0; i < 8; i++) regs[i] = 0;
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // the tests need about 300 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        results();
    end
    initial begin
        for (i = 0; i < 8; i++) regs[i] = 0;
        repeat (8) @(posedge clk);
        resetn <= 1;
        @(posedge clk);
        for (i = 2; i < 9; i++) rdchk(i * 4);
        for (i = 2; i < 8; i++) begin
            seed = lfsr(seed);
            bus(1, i * 4, seed);
        end
        for (i = 2; i < 9; i++) rdchk(i * 4);
        for (i = 2; i < 8; i++) bus(1, i * 4, 0);
        $display("registers done");
        bus(1, 8'h00, 1);
        repeat (3) @(posedge clk);
        chk("sleep clocks", 2'b01, {pwr.cpu_clk_en, pwr.periph_clk_en});
        want.processor_interrupt_controller_irq_pending <= 1;
        await(0, 1);
        want.processor_interrupt_controller_irq_pending <= 0;
        bus(0, 8'h04, 0);
        chk("status", 32'h101, rd);
        $display("sleep done");
        bus(1, 8'h08, 32'h3e0);
        for (k = 0; k < 2; k++) begin
            bus(1, 8'h00, 2);
            repeat (3) @(posedge clk);
            chk("deep ctl", 4'b0001, {pwr.main_clk_en, pwr.periph_clk_en, pwr.fro_en, pwr.flash_standby});
            want.usart_irq <= 1;
            want.spi_irq <= 1;
            want.i2c_irq <= 1;
            repeat (10) @(posedge clk);
            chk("deep held", 0, pwr.main_clk_en);
            want.usart_irq <= 0;
            want.spi_irq <= 0;
            want.i2c_irq <= 0;
            want.usb_need_clock <= (k == 0);
            want.serial_hw_wake_request <= (k == 1);
            await(0, 1);
            want.usb_need_clock <= 0;
            want.serial_hw_wake_request <= 0;
            bus(0, 8'h04, 0);
            chk("status", 32'h201, rd);
        end
        $display("deep done");
        bus(1, 8'h10, 5);
        bus(1, 8'h14, 3);
        bus(1, 8'h18, 32'hf);
        bus(1, 8'h1c, 1);
        bus(1, 8'h08, 32'h101f);
        for (k = 0; k < 6; k++) begin
            bus(1, 8'h00, 2);
            repeat (2) @(posedge clk);
            want <= src_for(k);
            await(0, 1);
            want <= '0;
            bus(0, 8'h04, 0);
            chk("status", 32'h201, rd);
        end
        $display("deep sources done");
        bus(1, 8'h10, 2);
        bus(1, 8'h00, 2);
        want.bod_event <= 1;
        leave_reset();
        want.bod_event <= 0;
        rdchk(8'h10);
        bus(0, 8'h04, 0);
        chk("status", 32'h301, rd);
        $display("brownout done");
        bus(1, 8'h18, 1);
        bus(1, 8'h08, 32'hffff);
        bus(1, 8'h00, 3);
        want.usb_need_clock <= 1;
        repeat (10) @(posedge clk);
        chk("dpd ctl", 3'b100, {pwr.pins_hiz, pwr.core_domain_pwr, pwr.dma_clk_en});
        want.usb_need_clock <= 0;
        want.rtc_alarm_armed <= 1;
        want.rtc_second_alarm_flag <= 1;
        repeat (5) @(posedge clk);
        chk("alarm irq", 1, rtc_irq);
        leave_reset();
        want.rtc_second_alarm_flag <= 0;
        rdchk(8'h08);
        rdchk(8'h18);
        bus(0, 8'h04, 0);
        chk("status", 32'h401, rd);
        $display("power-down done");
        bus(1, 8'h00, 2);
        resetn <= 0;
        repeat (2) @(posedge clk);
        resetn <= 1;
        for (i = 0; i < 8; i++) regs[i] = 0;
        @(posedge clk);
        bus(0, 8'h04, 0);
        chk("status", 32'h001, rd);
        chk("reset ctl", 1, pwr.cpu_clk_en);
        $display("reset pin done");
        results();
    end
endmodule
